// ==== design/ivm_vector_map.sv ====
`timescale 1ns/1ns
module ivm_vector_map #(
	parameter ivm_pkg::ivm_variant_t VARIANT = ivm_pkg::IVM_SMALL,
	parameter logic [ivm_pkg::ADDR_W-1:0] BOOT_BASE = ivm_pkg::BOOT_BASE_DEFAULT
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic bootResetSelectFuse,
	input wire logic vectorTableSelect,
	input wire logic [ivm_pkg::SRC_N-1:0] srcReq,
	input wire ivm_pkg::ivm_wdt_ctrl_t wdtCtrl,
	input wire logic vectorTaken,
	output logic [ivm_pkg::ADDR_W-1:0] resetVector,
	output logic irqValid,
	output ivm_pkg::ivm_offer_t irqOffer,
	output logic watchdogTimeoutFlag,
	output logic watchdogInterruptEnable
);
	localparam bit HAS_BOOT = (VARIANT != ivm_pkg::IVM_SMALL);
	localparam int WDT_BIT = int'(ivm_pkg::IDX_WATCHDOG) - 1;

	initial begin
		if (HAS_BOOT && (int'(BOOT_BASE) + 2 * (ivm_pkg::SRC_N + 1)
				>= (1 << ivm_pkg::ADDR_W))) begin
			$error("ivm_vector_map: boot table does not fit");
		end
		if (HAS_BOOT && BOOT_BASE == ivm_pkg::RESET_BASE) begin
			$error("ivm_vector_map: boot base equals reset base");
		end
	end

	typedef enum {IVM_IDLE, IVM_OFFER} ivm_state_t;

	// ----------------------------------------
	// fuse synchroniser and load window
	// ----------------------------------------
	logic fuseMeta_q;
	logic fuseSync_q;
	logic [1:0] fuseLoad_q;
	logic bootReset_q;
	logic tableSel_q;

	always_ff @(posedge clk) begin
		fuseMeta_q <= bootResetSelectFuse;
		fuseSync_q <= fuseMeta_q;
	end

	// fuse is a static strap, so only the settled value after reset matters
	always_ff @(posedge clk) begin
		if (rst) begin
			fuseLoad_q <= ivm_pkg::FUSE_LOAD_CYCLES;
		end else if (fuseLoad_q != 2'h0) begin
			fuseLoad_q <= fuseLoad_q - 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bootReset_q <= 1'b0;
		end else if (fuseLoad_q != 2'h0) begin
			bootReset_q <= HAS_BOOT && fuseSync_q;
		end
	end

	// control bit from the core clock domain, no synchroniser needed
	always_ff @(posedge clk) begin
		if (rst) begin
			tableSel_q <= 1'b0;
		end else begin
			tableSel_q <= HAS_BOOT && vectorTableSelect;
		end
	end

	// ----------------------------------------
	// reset vector
	// ----------------------------------------
	logic [ivm_pkg::ADDR_W-1:0] resetVector_q;
	logic [ivm_pkg::ADDR_W-1:0] resetVector_d;

	always_comb begin
		resetVector_d = ivm_pkg::RESET_BASE;
		if (bootReset_q) begin
			resetVector_d = BOOT_BASE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			resetVector_q <= ivm_pkg::RESET_BASE;
		end else begin
			resetVector_q <= resetVector_d;
		end
	end

	assign resetVector = resetVector_q;

	// ----------------------------------------
	// watchdog flag and request merge
	// ----------------------------------------
	ivm_state_t state_q;
	ivm_pkg::ivm_offer_t offer_q;
	logic wdtTaken;
	logic wdtReq;
	logic [ivm_pkg::SRC_N-1:0] pending;
	logic anyPending;
	logic [ivm_pkg::IDX_W-1:0] pickPos;

	assign wdtTaken = (state_q == IVM_OFFER) && vectorTaken
		&& (offer_q.index == ivm_pkg::IDX_WATCHDOG);

	ivm_wdt_flag u_wdt (
		.clk(clk),
		.rst(rst),
		.ctrl(wdtCtrl),
		.vectorTaken(wdtTaken),
		.flag(watchdogTimeoutFlag),
		.enable(watchdogInterruptEnable),
		.request(wdtReq)
	);

	// watchdog line comes from the local flag, never from the source bus
	always_comb begin
		pending = srcReq;
		pending[WDT_BIT] = wdtReq;
	end

	ivm_lowest_pick #(
		.N(ivm_pkg::SRC_N)
	) u_pick (
		.req(pending),
		.any(anyPending),
		.pos(pickPos)
	);

	// ----------------------------------------
	// offer to the core
	// ----------------------------------------
	logic [ivm_pkg::IDX_W-1:0] pickIdx;
	logic [ivm_pkg::ADDR_W-1:0] tableBase;

	assign pickIdx = pickPos + ivm_pkg::IDX_W'(1);
	assign tableBase = tableSel_q ? BOOT_BASE : ivm_pkg::RESET_BASE;

	// offer is frozen until taken, so the core never sees it change mid fetch
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= IVM_IDLE;
		end else begin
			case (state_q)
				IVM_IDLE: begin
					if (anyPending) begin
						state_q <= IVM_OFFER;
					end
				end
				IVM_OFFER: begin
					if (vectorTaken) begin
						state_q <= IVM_IDLE;
					end
				end
				default: begin
					state_q <= IVM_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			offer_q <= '0;
		end else if (state_q == IVM_IDLE && anyPending) begin
			offer_q.index <= pickIdx;
			offer_q.addr <= ivm_pkg::vecAddr(tableBase, pickIdx, VARIANT);
		end
	end

	assign irqValid = (state_q == IVM_OFFER);
	assign irqOffer = offer_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic [1:0] expWidth;
	assign expWidth = (VARIANT == ivm_pkg::IVM_LARGE) ? 2'h2 : 2'h1;

	a_offer_addr: assert property (
		$rose(irqValid) |-> irqOffer.addr == ($past(tableBase)
			+ ivm_pkg::ADDR_W'(irqOffer.index) * ivm_pkg::ADDR_W'(expWidth)))
		else $error("vector address not base plus index times width");

	a_small_table: assert property (
		(VARIANT == ivm_pkg::IVM_SMALL && irqValid)
			|-> irqOffer.addr == ivm_pkg::ADDR_W'(irqOffer.index))
		else $error("small variant table moved");

	a_small_reset: assert property (
		(VARIANT == ivm_pkg::IVM_SMALL) |-> resetVector == 13'h0000)
		else $error("small variant reset vector moved");

	a_reset_fuse: assert property (
		(HAS_BOOT && fuseLoad_q == 2'h0 && $stable(bootReset_q))
			|-> resetVector == (bootReset_q ? BOOT_BASE : 13'h0000))
		else $error("reset vector does not follow fuse");

	a_table_select: assert property (
		(HAS_BOOT && state_q == IVM_IDLE && anyPending && tableSel_q)
			|=> irqOffer.addr >= BOOT_BASE)
		else $error("vector table select ignored");

	a_lowest_first: assert property (
		(state_q == IVM_IDLE && pending[0]) |=> irqOffer.index == 5'h01)
		else $error("lowest request not chosen");

	a_no_lower_wins: assert property (
		(state_q == IVM_IDLE && anyPending)
			|=> (($past(pending) & ((25'h1 << (irqOffer.index - 5'h01)) - 25'h1)) == 25'h0))
		else $error("a lower request was passed over");

	a_wdt_index: assert property (
		(state_q == IVM_IDLE && wdtReq && pending[4:0] == 5'h00)
			|=> irqOffer.index == 5'h06)
		else $error("watchdog vector not index 6");

	a_wdt_clear: assert property (
		(wdtTaken && !wdtCtrl.timeout) |=> !watchdogTimeoutFlag)
		else $error("watchdog flag not cleared by vector");

	a_wdt_combined: assert property (
		(wdtTaken && wdtCtrl.resetMode && !wdtCtrl.enableWrite && !wdtCtrl.timeout)
			|=> !watchdogInterruptEnable && !watchdogTimeoutFlag)
		else $error("combined mode did not drop enable");

	a_offer_hold: assert property (
		(irqValid && !vectorTaken) |=> irqValid && $stable(irqOffer))
		else $error("offer changed before it was taken");

	c_wdt_taken: cover property (wdtTaken);
	c_two_pending: cover property (state_q == IVM_IDLE && $countones(pending) > 1);
	c_boot_table: cover property (irqValid && tableSel_q);
	c_last_vector: cover property (irqValid && irqOffer.index == ivm_pkg::IDX_FLASH_STORE);
endmodule // ivm_vector_map

// ==== design/ivm_pkg.sv ====
package ivm_pkg;
	localparam int ADDR_W = 13;
	localparam int IDX_W = 5;
	localparam int SRC_N = 25;

	// ----------------------------------------
	// table bases and widths
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] RESET_BASE = 13'h0000;
	localparam logic [ADDR_W-1:0] BOOT_BASE_DEFAULT = 13'h1000;
	localparam logic [1:0] WIDTH_NARROW = 2'h1;
	localparam logic [1:0] WIDTH_WIDE = 2'h2;
	localparam logic [1:0] FUSE_LOAD_CYCLES = 2'h3;

	// ----------------------------------------
	// vector indices, zero based
	// ----------------------------------------
	localparam logic [IDX_W-1:0] IDX_RESET = 5'h00;
	localparam logic [IDX_W-1:0] IDX_EXT_ZERO = 5'h01;
	localparam logic [IDX_W-1:0] IDX_EXT_ONE = 5'h02;
	localparam logic [IDX_W-1:0] IDX_PIN_GROUP0 = 5'h03;
	localparam logic [IDX_W-1:0] IDX_PIN_GROUP1 = 5'h04;
	localparam logic [IDX_W-1:0] IDX_PIN_GROUP2 = 5'h05;
	localparam logic [IDX_W-1:0] IDX_WATCHDOG = 5'h06;
	localparam logic [IDX_W-1:0] IDX_T2_MATCH_A = 5'h07;
	localparam logic [IDX_W-1:0] IDX_T2_MATCH_B = 5'h08;
	localparam logic [IDX_W-1:0] IDX_T2_WRAP = 5'h09;
	localparam logic [IDX_W-1:0] IDX_T1_CAPTURE = 5'h0A;
	localparam logic [IDX_W-1:0] IDX_T1_MATCH_A = 5'h0B;
	localparam logic [IDX_W-1:0] IDX_T1_MATCH_B = 5'h0C;
	localparam logic [IDX_W-1:0] IDX_T1_WRAP = 5'h0D;
	localparam logic [IDX_W-1:0] IDX_T0_MATCH_A = 5'h0E;
	localparam logic [IDX_W-1:0] IDX_T0_MATCH_B = 5'h0F;
	localparam logic [IDX_W-1:0] IDX_T0_WRAP = 5'h10;
	localparam logic [IDX_W-1:0] IDX_SERIAL_DONE = 5'h11;
	localparam logic [IDX_W-1:0] IDX_UART_RX_DONE = 5'h12;
	localparam logic [IDX_W-1:0] IDX_UART_TX_EMPTY = 5'h13;
	localparam logic [IDX_W-1:0] IDX_UART_TX_DONE = 5'h14;
	localparam logic [IDX_W-1:0] IDX_ADC_DONE = 5'h15;
	localparam logic [IDX_W-1:0] IDX_EEPROM_READY = 5'h16;
	localparam logic [IDX_W-1:0] IDX_COMPARATOR = 5'h17;
	localparam logic [IDX_W-1:0] IDX_TWO_WIRE = 5'h18;
	localparam logic [IDX_W-1:0] IDX_FLASH_STORE = 5'h19;

	typedef enum logic [1:0] {IVM_SMALL, IVM_MID, IVM_LARGE} ivm_variant_t;

	typedef struct packed {
		logic [IDX_W-1:0] index;
		logic [ADDR_W-1:0] addr;
	} ivm_offer_t;

	typedef struct packed {
		logic timeout;
		logic enableWrite;
		logic enableValue;
		logic flagWriteOne;
		logic resetMode;
	} ivm_wdt_ctrl_t;

	function automatic logic [1:0] vecWidth(input ivm_variant_t v);
		vecWidth = (v == IVM_LARGE) ? WIDTH_WIDE : WIDTH_NARROW;
	endfunction

	function automatic logic [ADDR_W-1:0] vecAddr(input logic [ADDR_W-1:0] base,
			input logic [IDX_W-1:0] idx, input ivm_variant_t v);
		logic [ADDR_W-1:0] step;
		step = ADDR_W'(idx) * ADDR_W'(vecWidth(v));
		vecAddr = base + step;
	endfunction
endpackage

// ==== design/ivm_lowest_pick.sv ====
`timescale 1ns/1ns
module ivm_lowest_pick #(
	parameter int N = ivm_pkg::SRC_N
) (
	input wire logic [N-1:0] req,
	output logic any,
	output logic [ivm_pkg::IDX_W-1:0] pos
);
	initial begin
		if (N < 1 || N >= (1 << ivm_pkg::IDX_W)) begin
			$error("ivm_lowest_pick: N out of range");
		end
	end

	// ----------------------------------------
	// scan from the top so the lowest bit wins
	// ----------------------------------------
	always_comb begin
		any = 1'b0;
		pos = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				pos = ivm_pkg::IDX_W'(i);
			end
		end
	end
endmodule // ivm_lowest_pick

// ==== design/ivm_wdt_flag.sv ====
`timescale 1ns/1ns
module ivm_wdt_flag (
	input wire logic clk,
	input wire logic rst,
	input wire ivm_pkg::ivm_wdt_ctrl_t ctrl,
	input wire logic vectorTaken,
	output logic flag,
	output logic enable,
	output logic request
);
	logic flag_q;
	logic enable_q;

	// ----------------------------------------
	// timeout flag; a timeout while enabled beats any clear
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else if (ctrl.timeout && enable_q) begin
			flag_q <= 1'b1;
		end else if (vectorTaken || ctrl.flagWriteOne) begin
			flag_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// interrupt enable; software write wins over the hardware clear
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			enable_q <= 1'b0;
		end else if (ctrl.enableWrite) begin
			enable_q <= ctrl.enableValue;
		end else if (vectorTaken && ctrl.resetMode) begin
			enable_q <= 1'b0;
		end
	end

	assign flag = flag_q;
	assign enable = enable_q;
	assign request = flag_q && enable_q;
endmodule // ivm_wdt_flag

// ==== dv/ivm_core_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// core side: takes each offered vector
// ----------------------------------------
// one-cycle take pulse after a chosen delay; stall holds off the take
module ivm_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic irqValid,
	input wire logic stall,
	input wire logic [1:0] delay,
	output logic vectorTaken
);
	logic [1:0] waitCnt_q;

	// pulse drops at once so a standing offer is never taken twice
	always_ff @(posedge clk) begin
		if (rst || !irqValid || vectorTaken) begin
			vectorTaken <= 1'b0;
			waitCnt_q <= delay;
		end else if (!stall && waitCnt_q == 2'h0) begin
			vectorTaken <= 1'b1;
		end else if (!stall) begin
			waitCnt_q <= waitCnt_q - 2'h1;
		end
	end
endmodule // ivm_core_model

// ==== dv/tb_interrupt_vector_address_map.sv ====
`timescale 1ns/1ns
module tb_interrupt_vector_address_map;
	localparam logic [12:0] BOOT = 13'h0800;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic fuse = 1'b1;
	logic tblSel = 1'b0;
	logic [24:0] srcReq = '0;
	logic [4:0] wdtCtrl = '0;
	logic stall = 1'b0;
	logic [1:0] delay = 2'h0;
	logic vectorTaken, irqValid, wdtFlag, wdtEnable;
	logic [12:0] resetVector;
	ivm_pkg::ivm_offer_t irqOffer;
	ivm_pkg::ivm_offer_t expQ[$];
	int fails = 0;
	int checks = 0;
	int cycles = 0;

	always #10 clk = ~clk;

	ivm_vector_map #(.VARIANT(ivm_pkg::IVM_MID), .BOOT_BASE(BOOT)) uut (
		.clk(clk), .rst(rst), .bootResetSelectFuse(fuse), .vectorTableSelect(tblSel),
		.srcReq(srcReq), .wdtCtrl(ivm_pkg::ivm_wdt_ctrl_t'(wdtCtrl)),
		.vectorTaken(vectorTaken), .resetVector(resetVector), .irqValid(irqValid),
		.irqOffer(irqOffer), .watchdogTimeoutFlag(wdtFlag),
		.watchdogInterruptEnable(wdtEnable)
	);

	ivm_core_model core (
		.clk(clk), .rst(rst), .irqValid(irqValid), .stall(stall), .delay(delay),
		.vectorTaken(vectorTaken)
	);

	// ----------------------------------------
	// checking and verdict
	// ----------------------------------------
	task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		if (fails == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// one width on the mid variant, so address is base plus index
	function automatic ivm_pkg::ivm_offer_t mk(input logic [4:0] idx, input logic sel);
		mk.index = idx;
		mk.addr = (sel ? BOOT : 13'h0000) + 13'(idx);
	endfunction

	// oldest note against every taken offer
	always @(posedge clk) begin
		if (rst === 1'b0 && irqValid === 1'b1 && vectorTaken === 1'b1) begin
			chk(irqOffer, (expQ.size() > 0) ? expQ.pop_front() : '1);
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			fails++;
			close_out();
		end
	end

	// ----------------------------------------
	// drivers
	// ----------------------------------------
	task automatic waitTake;
		do @(negedge clk); while (!(irqValid === 1'b1 && vectorTaken === 1'b1));
		@(posedge clk);
	endtask

	task automatic doReset(input logic f);
		fuse <= f;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk(18'(resetVector), f ? 18'(BOOT) : 18'h0_0000);
		@(posedge clk);
	endtask

	// level requests stay up until their own vector is taken
	task automatic serve(input logic [24:0] mask);
		logic sel;
		int low;
		sel = 1'($urandom_range(0, 1));
		tblSel <= sel;
		delay <= 2'($urandom_range(0, 3));
		repeat (2) @(posedge clk);
		srcReq <= mask;
		while (mask != '0) begin
			for (int i = 24; i >= 0; i--) begin
				if (mask[i]) begin
					low = i;
				end
			end
			expQ.push_back(mk(5'(low + 1), sel));
			waitTake();
			mask[low] = 1'b0;
			srcReq <= mask;
		end
	endtask

	// ctrl bits: timeout, enable write, enable value, write one, reset mode
	task automatic wdt(input logic combined, input logic swClear);
		tblSel <= 1'b0;
		stall <= swClear;
		wdtCtrl <= {4'h6, combined};
		@(posedge clk);
		wdtCtrl <= {4'h0, combined};
		@(posedge clk);
		wdtCtrl <= {4'h8, combined};
		expQ.push_back(mk(5'h06, 1'b0));
		@(posedge clk);
		wdtCtrl <= {4'h0, combined};
		repeat (2) @(negedge clk);
		chk(18'(wdtFlag), 18'h0_0001);
		if (swClear) begin
			@(posedge clk);
			wdtCtrl <= {4'h1, combined};
			@(posedge clk);
			wdtCtrl <= {4'h0, combined};
			@(negedge clk);
			chk(18'(wdtFlag), 18'h0_0000);
			@(posedge clk);
			stall <= 1'b0;
		end
		waitTake();
		@(negedge clk);
		chk(18'(wdtFlag), 18'h0_0000);
		chk(18'(wdtEnable), 18'(!combined));
		@(posedge clk);
		wdtCtrl <= 5'h0c;
		@(posedge clk);
		wdtCtrl <= 5'h00;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(49825));
		doReset(1'b1);
		for (int i = 0; i < 25; i++) begin
			if (i != 5) begin
				serve(25'h000_0001 << i);
			end
		end
		repeat (30) begin
			serve(25'($urandom) & 25'h1ff_ffdf);
		end
		wdt(1'b0, 1'b0);
		wdt(1'b1, 1'b0);
		wdt(1'b0, 1'b1);
		doReset(1'b0);
		serve(25'h100_0000);
		repeat (4) @(posedge clk);
		chk(18'(expQ.size()), 18'h0_0000);
		close_out();
	end
endmodule // tb_interrupt_vector_address_map
